// File: design/uetc_endpoint.sv
// Endpoint control register and transmit-side state machine
//
// The address-and-strobe port and the register addresses were left to the implementer.
module uetc_endpoint
    import uetc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic tok_valid_in,
    input wire uetc_token_s tok_in,
    input wire logic txend_valid_in,
    input wire uetc_txend_s txend_in,
    input wire logic [1:0] rx_stat_in,
    input wire logic [1:0] double_buffer_enable_free_in,
    input wire logic bus_reset_in,
    output uetc_answer_s answer_out,
    output logic answer_valid_out,
    output logic tx_buf_sel_out,
    output logic ep_irq_out,
    output logic gen_irq_out
);
`include "uetc_defines.svh"

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Register fields
    // ----------------------------------------
    uetc_type_e endpoint_type_field;
    logic endpoint_kind_bit;
    logic tx_done;
    logic tx_tog;
    uetc_stat_e tx_stat;
    logic [3:0] ep_num;
    logic done_mask;
    logic setup_seen;
    logic in_pending;

    wire logic wr_epcs = reg_wr_in && (reg_addr_in == `UETC_ADDR_EPCS);
    wire logic wr_ctrl = reg_wr_in && (reg_addr_in == `UETC_ADDR_CTRL);
    wire logic hit = tok_valid_in && (tok_in.number == ep_num);
    wire logic is_ctrl = (endpoint_type_field == UETC_CONTROL);
    wire logic is_iso = (endpoint_type_field == UETC_ISO);
    wire logic dbl = (endpoint_type_field == UETC_BULK) && endpoint_kind_bit;
    wire logic setup_hit = hit && (tok_in.kind == UETC_TOK_SETUP) && is_ctrl;
    wire logic setup_take = setup_hit && (rx_stat_in != 2'h2) && (rx_stat_in != 2'h0);
    wire logic tx_end = txend_valid_in && in_pending;
    wire logic tx_good = tx_end && txend_in.sent && !txend_in.error &&
        (is_iso || txend_in.acked);

    // ----------------------------------------
    // Token decode for the checks
    // ----------------------------------------
    wire logic in_hit = hit && (tok_in.kind == UETC_TOK_IN);
    wire logic out_hit = hit && (tok_in.kind == UETC_TOK_OUT);
    wire logic setup_any = hit && (tok_in.kind == UETC_TOK_SETUP);
    wire logic tog_wr = wr_epcs && reg_wdata_in[`UETC_TOG_BIT];
    wire logic stat_quiet = !wr_epcs && !bus_reset_in;

    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Configuration fields
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            endpoint_type_field <= UETC_BULK;
            endpoint_kind_bit <= 1'b0;
            ep_num <= 4'h0;
            done_mask <= 1'b0;
        end else begin
            if (wr_epcs) begin
                endpoint_type_field <= uetc_type_e'(reg_wdata_in[`UETC_TYPE_HI:`UETC_TYPE_LO]);
                endpoint_kind_bit <= reg_wdata_in[`UETC_KIND_BIT];
                ep_num <= reg_wdata_in[`UETC_NUM_HI:`UETC_NUM_LO];
            end
            if (wr_ctrl) begin
                done_mask <= reg_wdata_in[`UETC_MASK_BIT];
            end
        end
    end

    // ----------------------------------------
    // Transmit done flag, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_done <= 1'b0;
        end else if (tx_good) begin
            tx_done <= 1'b1;
        end else if (wr_epcs && !reg_wdata_in[`UETC_TXDONE_BIT]) begin
            tx_done <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmit toggle
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_tog <= 1'b0;
        end else if (bus_reset_in) begin
            tx_tog <= 1'b0;
        end else if (setup_hit) begin
            tx_tog <= 1'b1;
        end else begin
            if (tx_good ^ (wr_epcs && reg_wdata_in[`UETC_TOG_BIT])) begin
                tx_tog <= !tx_tog;
            end
        end
    end

    // ----------------------------------------
    // Transmit status
    // ----------------------------------------
    logic [1:0] next_stat;
    always_comb begin
        next_stat = tx_stat;
        if (bus_reset_in) begin
            next_stat = UETC_DISABLED;
        end else if (wr_epcs) begin
            next_stat = tx_stat ^ reg_wdata_in[`UETC_STAT_HI:`UETC_STAT_LO];
        end else if (is_iso) begin
            next_stat = tx_stat;
        end else if (dbl && tx_good) begin
            next_stat = (double_buffer_enable_free_in == 2'h0) ? UETC_NAK : UETC_VALID;
        end else if (tx_good || setup_take) begin
            next_stat = UETC_NAK;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_stat <= UETC_DISABLED;
        end else begin
            tx_stat <= uetc_stat_e'(next_stat);
        end
    end

    // ----------------------------------------
    // Transaction tracking
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            in_pending <= 1'b0;
            setup_seen <= 1'b0;
        end else begin
            if (hit && tok_in.kind == UETC_TOK_IN && tx_stat == UETC_VALID) begin
                in_pending <= 1'b1;
            end else if (tx_end || bus_reset_in) begin
                in_pending <= 1'b0;
            end
            if (setup_take) begin
                setup_seen <= 1'b1;
            end else if (hit && tok_in.kind != UETC_TOK_SETUP && is_ctrl) begin
                setup_seen <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Token answer
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            answer_out <= '0;
            answer_valid_out <= 1'b0;
        end else begin
            answer_out <= '0;
            answer_valid_out <= 1'b0;
            if (hit) begin
                answer_valid_out <= 1'b1;
                case (tok_in.kind)
                    UETC_TOK_IN: begin
                        case (tx_stat)
                            UETC_STALL: answer_out.handshake <= UETC_HS_STALL;
                            UETC_NAK: answer_out.handshake <= UETC_HS_NAK;
                            UETC_VALID: begin
                                answer_out.send_data <= 1'b1;
                                answer_out.data_pid <= is_iso ? 1'b0 : tx_tog;
                            end
                            default: answer_valid_out <= 1'b0;
                        endcase
                    end
                    UETC_TOK_OUT: begin
                        if (is_ctrl && endpoint_kind_bit && tok_in.has_data &&
                            rx_stat_in == 2'h3) begin
                            answer_out.handshake <= UETC_HS_STALL;
                        end else begin
                            case (rx_stat_in)
                                2'h1: answer_out.handshake <= UETC_HS_STALL;
                                2'h2: answer_out.handshake <= UETC_HS_NAK;
                                2'h3: answer_out.handshake <= is_iso ? UETC_HS_NONE : UETC_HS_ACK;
                                default: answer_valid_out <= 1'b0;
                            endcase
                        end
                    end
                    UETC_TOK_SETUP: begin
                        if (setup_take) begin
                            answer_out.handshake <= UETC_HS_ACK;
                            answer_out.setup_accept <= 1'b1;
                        end else begin
                            answer_valid_out <= 1'b0;
                        end
                    end
                    default: answer_valid_out <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read data and interrupts
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= `UETC_RESET_EPCS;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `UETC_ADDR_EPCS: reg_rdata_out <= {5'h00, endpoint_type_field, endpoint_kind_bit, tx_done, tx_tog,
                    tx_stat, ep_num};
                `UETC_ADDR_CTRL: reg_rdata_out <= {15'h0000, done_mask};
                `UETC_ADDR_EVT: reg_rdata_out <= {14'h0000, setup_seen, in_pending};
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    assign ep_irq_out = tx_done;
    assign gen_irq_out = tx_done && done_mask;
    assign tx_buf_sel_out = tx_tog;

    // ----------------------------------------
    // Done flag checks
    // ----------------------------------------
    a_done_sets: assert property (
        tx_good |=> tx_done)
        else $error("done flag not set");
    a_done_clear: assert property (
        (wr_epcs && !reg_wdata_in[`UETC_TXDONE_BIT] && !tx_good) |=> !tx_done)
        else $error("done flag not cleared");
    a_done_hold: assert property (
        (!tx_good && !wr_epcs) |=> $stable(tx_done))
        else $error("done flag moved");
    a_done_keep: assert property (
        (wr_epcs && reg_wdata_in[`UETC_TXDONE_BIT] && tx_done) |=> tx_done)
        else $error("done flag lost on write one");
    a_gen_irq: assert property (
        gen_irq_out |-> (ep_irq_out && done_mask))
        else $error("generic irq wrong");

    // ----------------------------------------
    // Toggle checks
    // ----------------------------------------
    a_setup_tog: assert property (
        (setup_hit && !bus_reset_in) |=> tx_tog)
        else $error("toggle not forced");
    a_tog_ack: assert property (
        (tx_good && !setup_hit && !tog_wr && !bus_reset_in)
        |=> tx_tog != $past(tx_tog))
        else $error("toggle not flipped");
    a_tog_write: assert property (
        (tog_wr && !tx_good && !setup_hit && !bus_reset_in)
        |=> tx_tog != $past(tx_tog))
        else $error("toggle write ignored");
    a_tog_hold: assert property (
        (!tx_good && !tog_wr && !setup_hit && !bus_reset_in)
        |=> $stable(tx_tog))
        else $error("toggle moved");

    // ----------------------------------------
    // Status checks
    // ----------------------------------------
    a_stat_write: assert property (
        (wr_epcs && !bus_reset_in)
        |=> tx_stat == ($past(tx_stat) ^ $past(reg_wdata_in[`UETC_STAT_HI:`UETC_STAT_LO])))
        else $error("status write wrong");
    a_stat_nak: assert property (
        (tx_good && !is_iso && !dbl && stat_quiet) |=> tx_stat == UETC_NAK)
        else $error("status not NAK");
    a_setup_stat: assert property (
        (setup_take && stat_quiet) |=> tx_stat == UETC_NAK)
        else $error("setup left status");
    a_stat_hold: assert property (
        (tx_stat == UETC_NAK && !tx_good && !setup_take && stat_quiet)
        |=> tx_stat == UETC_NAK)
        else $error("status left NAK");
    a_dbl_stat: assert property (
        (dbl && tx_good && stat_quiet)
        |=> tx_stat == (($past(double_buffer_enable_free_in) == 2'h0) ? UETC_NAK : UETC_VALID))
        else $error("double buffer status wrong");
    a_iso_stat: assert property (
        (is_iso && stat_quiet) |=> $stable(tx_stat))
        else $error("iso status changed");

    // ----------------------------------------
    // Answer checks
    // ----------------------------------------
    a_setup_nak: assert property (
        (setup_hit && rx_stat_in == 2'h2) |=> !answer_valid_out)
        else $error("answered nak setup");
    a_setup_other: assert property (
        (setup_any && !is_ctrl) |=> !answer_valid_out)
        else $error("setup answered on non-control");
    a_setup_stall: assert property (
        (setup_hit && rx_stat_in == 2'h1) |=> answer_valid_out && answer_out.setup_accept)
        else $error("stalled setup refused");
    a_status_out: assert property (
        (out_hit && is_ctrl && endpoint_kind_bit && tok_in.has_data && rx_stat_in == 2'h3)
        |=> answer_out.handshake == UETC_HS_STALL)
        else $error("status out not stalled");
    a_out_nak: assert property (
        (out_hit && rx_stat_in == 2'h2) |=> answer_out.handshake == UETC_HS_NAK)
        else $error("out not naked");
    a_out_stall: assert property (
        (out_hit && rx_stat_in == 2'h1) |=> answer_out.handshake == UETC_HS_STALL)
        else $error("stalled out not answered");
    a_out_off: assert property (
        (out_hit && rx_stat_in == 2'h0) |=> !answer_valid_out)
        else $error("disabled out answered");
    a_ctrl_out: assert property (
        (out_hit && is_ctrl && !endpoint_kind_bit && rx_stat_in == 2'h3) |=> answer_out.handshake == UETC_HS_ACK)
        else $error("control out not acked");
    a_bulk_ack: assert property (
        (out_hit && !is_iso && !is_ctrl && rx_stat_in == 2'h3) |=> answer_out.handshake == UETC_HS_ACK)
        else $error("bulk out not acked");
    a_in_pid: assert property (
        (in_hit && !is_iso && tx_stat == UETC_VALID)
        |=> answer_out.send_data && answer_out.data_pid == $past(tx_tog))
        else $error("wrong data pid");
    a_iso_pid: assert property (
        (in_hit && is_iso && tx_stat == UETC_VALID) |=> !answer_out.data_pid)
        else $error("iso pid not DATA0");
    a_in_stat: assert property (
        (in_hit && tx_stat == UETC_STALL) |=> answer_out.handshake == UETC_HS_STALL)
        else $error("stall not answered");
    a_in_nak: assert property (
        (in_hit && tx_stat == UETC_NAK) |=> answer_out.handshake == UETC_HS_NAK)
        else $error("nak not answered");
    a_in_off: assert property (
        (in_hit && tx_stat == UETC_DISABLED) |=> !answer_valid_out)
        else $error("disabled endpoint answered");
    a_no_match: assert property (
        (tok_valid_in && tok_in.number != ep_num) |=> !answer_valid_out)
        else $error("foreign token answered");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_in_done: cover property (tx_good);
    c_setup: cover property (setup_take);
    c_stall_out: cover property (answer_valid_out && answer_out.handshake == UETC_HS_STALL);
    c_dbl_nak: cover property (dbl && tx_good && double_buffer_enable_free_in == 2'h0);
    c_iso_done: cover property (is_iso && tx_good);
endmodule

// File: shared/uetc_defines.svh
// Constants for the endpoint control and transmit block
//
// Behaviour
// - Type field at bits 10:9 selects bulk, control, isochronous or interrupt behaviour.
// - SETUP handled only on control endpoints; ignored on all other types.
// - SETUP on control endpoint with receive NAK gets no handshake at all.
// - SETUP on control endpoint with receive STALL is accepted, sets setup_seen.
// - OUT on control endpoint with kind clear follows normal receive status handling.
// - Bulk and interrupt behave alike except for the kind bit feature.
// - Kind bit 8 meaning follows type; on bulk it enables double buffering.
// - Control with kind set: OUT with data answered STALL; clear accepts any.
// - Transmit done flag at bit 7 sets on each successful IN transaction.
// - Done sets endpoint interrupt always; generic interrupt when mask bit set.
// - NAK, STALL, errors and toggle mismatches leave transmit done unchanged.
// - Software write 0 clears transmit done; write 1 leaves it.
// - Toggle bit 6 gives next data PID; flips on host ACK.
// - SETUP on control endpoint forces transmit toggle to 1.
// - Isochronous sends DATA0 only; toggle selects buffer, flips after each packet sent without error.
// - Toggle write 1 inverts, write 0 keeps; software initialises it so.
// - Each transmit status bit 5:4 inverts on write 1, keeps on 0.
// - Correct IN on single-buffered non-iso endpoint, or control SETUP, sets transmit status NAK.
// - Double-buffered bulk status follows availability of the two buffers.
// - Isochronous transmit status is changed by hardware only on bus reset, which sets it disabled.
// - Four-bit number field at bits 3:0 matched against token endpoint numbers.
// - Transmit status: 00 disabled, 01 stall, 10 NAK, 11 valid.
// - Type encoding: 00 bulk, 01 control, 10 isochronous, 11 interrupt.
// - Receive status NAK answers every OUT token with NAK.
`ifndef UETC_DEFINES_SVH
`define UETC_DEFINES_SVH

`define UETC_ADDR_EPCS 4'h0
`define UETC_ADDR_CTRL 4'h1
`define UETC_ADDR_EVT 4'h2

`define UETC_TYPE_HI 10
`define UETC_TYPE_LO 9
`define UETC_KIND_BIT 8
`define UETC_TXDONE_BIT 7
`define UETC_TOG_BIT 6
`define UETC_STAT_HI 5
`define UETC_STAT_LO 4
`define UETC_NUM_HI 3
`define UETC_NUM_LO 0
`define UETC_MASK_BIT 0

`define UETC_RESET_EPCS 16'h0000

`endif

// File: shared/uetc_pkg.sv
// Types for the endpoint control and transmit block
package uetc_pkg;
    typedef enum logic [1:0] {
        UETC_BULK = 2'h0,
        UETC_CONTROL = 2'h1,
        UETC_ISO = 2'h2,
        UETC_INTR = 2'h3
    } uetc_type_e;

    typedef enum logic [1:0] {
        UETC_DISABLED = 2'h0,
        UETC_STALL = 2'h1,
        UETC_NAK = 2'h2,
        UETC_VALID = 2'h3
    } uetc_stat_e;

    typedef enum logic [1:0] {
        UETC_HS_NONE = 2'h0,
        UETC_HS_ACK = 2'h1,
        UETC_HS_NAK = 2'h2,
        UETC_HS_STALL = 2'h3
    } uetc_hs_e;

    typedef enum logic [1:0] {
        UETC_TOK_IN = 2'h0,
        UETC_TOK_OUT = 2'h1,
        UETC_TOK_SETUP = 2'h3
    } uetc_tok_e;

    // Token from the serial engine
    typedef struct packed {
        uetc_tok_e kind;
        logic [3:0] number;
        logic has_data;
    } uetc_token_s;

    // End of an IN data phase from the serial engine
    typedef struct packed {
        logic sent;
        logic acked;
        logic error;
    } uetc_txend_s;

    // Answer to a token
    typedef struct packed {
        uetc_hs_e handshake;
        logic send_data;
        logic data_pid;
        logic setup_accept;
    } uetc_answer_s;
endpackage

// File: verif/uetc_host_model.sv
// Host model that issues tokens and closes IN data phases
module uetc_host_model
    import uetc_pkg::*;
(
    input wire logic clk_in,
    input wire logic answer_valid_in,
    input wire uetc_answer_s answer_in,
    output logic tok_valid_out,
    output uetc_token_s tok_out,
    output logic txend_valid_out,
    output uetc_txend_s txend_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic got_valid;
    uetc_answer_s got;

    initial begin
        tok_valid_out = 1'b0;
        tok_out = '0;
        txend_valid_out = 1'b0;
        txend_out = '0;
        got_valid = 1'b0;
        got = '0;
    end

    // --------------------------------------------------------------
    // Token with the device's answer taken one cycle later
    // --------------------------------------------------------------
    task automatic send_token(input uetc_tok_e k, input logic [3:0] n, input logic d);
        @(posedge clk_in);
        tok_valid_out <= 1'b1;
        tok_out <= '{kind: k, number: n, has_data: d};
        @(posedge clk_in);
        tok_valid_out <= 1'b0;
        // Released lines must not keep the last value
        tok_out <= ~tok_out;
        #1;
        got_valid = answer_valid_in;
        got = answer_in;
    endtask

    // --------------------------------------------------------------
    // End of an IN data phase, acked or not
    // --------------------------------------------------------------
    task automatic end_tx(input logic sent, input logic acked, input logic err);
        @(posedge clk_in);
        txend_valid_out <= 1'b1;
        txend_out <= '{sent: sent, acked: acked, error: err};
        @(posedge clk_in);
        txend_valid_out <= 1'b0;
        txend_out <= ~txend_out;
        #1;
    endtask
endmodule

// File: verif/usb_endpoint_tx_control_tb.sv
// Self-checking testbench for the endpoint control and transmit block
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module usb_endpoint_tx_control_tb
    import uetc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        uetc_type_e ty;
        logic acked;
        logic [15:0] exp;
    } uetc_row_s;

    logic clk, arst_n, wr, rd, bus_reset;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, val;
    logic [1:0] rx_stat, dbl_free;
    logic tok_valid, txend_valid, ans_valid, buf_sel, ep_irq, gen_irq, got_v;
    uetc_token_s tok;
    uetc_txend_s txend;
    uetc_answer_s answer, got;
    int err_total, checks;
    uetc_row_s rows [4];

    uetc_endpoint uetc_endpoint_i (.clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .tok_valid_in(tok_valid), .tok_in(tok), .txend_valid_in(txend_valid),
        .txend_in(txend), .rx_stat_in(rx_stat), .double_buffer_enable_free_in(dbl_free),
        .bus_reset_in(bus_reset), .answer_out(answer), .answer_valid_out(ans_valid),
        .tx_buf_sel_out(buf_sel), .ep_irq_out(ep_irq), .gen_irq_out(gen_irq));

    uetc_host_model uetc_host_model_i (.clk_in(clk), .answer_valid_in(ans_valid),
        .answer_in(answer), .tok_valid_out(tok_valid), .tok_out(tok),
        .txend_valid_out(txend_valid), .txend_out(txend));

    // --------------------------------------------------------------
    // Register bus and host helpers
    // --------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        val = rdata;
    endtask

    task automatic tok_go(input uetc_tok_e k, input logic [3:0] n, input logic d);
        uetc_host_model_i.send_token(k, n, d);
        got_v = uetc_host_model_i.got_valid;
        got = uetc_host_model_i.got;
    endtask

    // Bus reset, then number first and enable after it
    task automatic setup_ep(input uetc_type_e ty, input logic kind);
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
        wr_reg(4'h0, {5'h00, ty, kind, 2'h0, 2'h0, 4'h5});
        wr_reg(4'h0, {5'h00, ty, kind, 2'h0, 2'h3, 4'h5});
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        bus_reset = 1'b0;
        rx_stat = 2'h3;
        dbl_free = 2'h3;
        err_total = 0;
        checks = 0;
        rows[0] = '{UETC_BULK, 1'b1, 16'h00e5};
        rows[1] = '{UETC_CONTROL, 1'b1, 16'h02e5};
        rows[2] = '{UETC_ISO, 1'b0, 16'h04f5};
        rows[3] = '{UETC_INTR, 1'b1, 16'h06e5};
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(4'h0);
        `CHK(val, 16'h0000)
        rd_reg(4'h3);
        `CHK(val, 16'h0000)
        foreach (rows[i]) begin
            setup_ep(rows[i].ty, 1'b0);
            tok_go(UETC_TOK_IN, 4'h5, 1'b0);
            `CHK(got_v, 1'b1)
            `CHK(got.send_data, 1'b1)
            `CHK(got.data_pid, 1'b0)
            uetc_host_model_i.end_tx(1'b1, rows[i].acked, 1'b0);
            rd_reg(4'h0);
            `CHK(val, rows[i].exp)
            `CHK(ep_irq, 1'b1)
            `CHK(buf_sel, 1'b1)
        end
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got.handshake, UETC_HS_NAK)
        rd_reg(4'h0);
        `CHK(val, 16'h06e5)
        `CHK(gen_irq, 1'b0)
        wr_reg(4'h1, 16'h0001);
        `CHK(gen_irq, 1'b1)
        wr_reg(4'h0, 16'h0685);
        `CHK(ep_irq, 1'b1)
        wr_reg(4'h0, 16'h0605);
        `CHK(gen_irq, 1'b0)
        wr_reg(4'h0, 16'h0645);
        rd_reg(4'h0);
        `CHK(val, 16'h0625)
        wr_reg(4'h0, 16'h0635);
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got.handshake, UETC_HS_STALL)
        wr_reg(4'h0, 16'h0615);
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got_v, 1'b0)
        wr_reg(4'h0, 16'h0635);
        tok_go(UETC_TOK_IN, 4'h6, 1'b0);
        `CHK(got_v, 1'b0)
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        uetc_host_model_i.end_tx(1'b1, 1'b0, 1'b1);
        rd_reg(4'h0);
        `CHK(val, 16'h0635)
        setup_ep(UETC_CONTROL, 1'b0);
        @(posedge clk) rx_stat <= 2'h2;
        tok_go(UETC_TOK_SETUP, 4'h5, 1'b1);
        `CHK(got_v, 1'b0)
        @(posedge clk) rx_stat <= 2'h1;
        tok_go(UETC_TOK_SETUP, 4'h5, 1'b1);
        `CHK(got.setup_accept, 1'b1)
        rd_reg(4'h0);
        `CHK(val, 16'h0265)
        rd_reg(4'h2);
        `CHK(val, 16'h0002)
        setup_ep(UETC_BULK, 1'b0);
        tok_go(UETC_TOK_SETUP, 4'h5, 1'b1);
        `CHK(got_v, 1'b0)
        setup_ep(UETC_CONTROL, 1'b1);
        @(posedge clk) rx_stat <= 2'h3;
        tok_go(UETC_TOK_OUT, 4'h5, 1'b1);
        `CHK(got.handshake, UETC_HS_STALL)
        tok_go(UETC_TOK_OUT, 4'h5, 1'b0);
        `CHK(got.handshake, UETC_HS_ACK)
        setup_ep(UETC_CONTROL, 1'b0);
        tok_go(UETC_TOK_OUT, 4'h5, 1'b1);
        `CHK(got.handshake, UETC_HS_ACK)
        @(posedge clk) rx_stat <= 2'h2;
        tok_go(UETC_TOK_OUT, 4'h5, 1'b1);
        `CHK(got.handshake, UETC_HS_NAK)
        setup_ep(UETC_BULK, 1'b1);
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got.send_data, 1'b1)
        uetc_host_model_i.end_tx(1'b1, 1'b1, 1'b0);
        @(posedge clk) dbl_free <= 2'h0;
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got.data_pid, 1'b1)
        uetc_host_model_i.end_tx(1'b1, 1'b1, 1'b0);
        tok_go(UETC_TOK_IN, 4'h5, 1'b0);
        `CHK(got.handshake, UETC_HS_NAK)
        wrap_up();
    end
endmodule
